// file: hdl/ddc_cfg.svh
`ifndef DDC_CFG_SVH
`define DDC_CFG_SVH
`define DDC_CLK_NS 100
`define DDC_TAG_HEAD 3'h1
`define DDC_TAG_TRACK 3'h2
`define DDC_TAG_SENSE0 3'h4
`define DDC_CAL_TRACK 9'h080
`define DDC_SLOW_PRESET 3'h7
`define DDC_MODULES 3'h5
`define DDC_STEP_NS 1900000
`define DDC_POD_S 17
`define DDC_SETTLE_NS 100000
`define DDC_RESYNC_NS 300
`define DDC_WR_HALF 2
`define DDC_FIFO_DEPTH 8
`define DDC_GAIN_W 5
`define DDC_STEP_CYC ((`DDC_STEP_NS + `DDC_CLK_NS - 1) / `DDC_CLK_NS)
`define DDC_POD_CYC (`DDC_POD_S * (1000000000 / `DDC_CLK_NS))
`define DDC_SETTLE_CYC ((`DDC_SETTLE_NS + `DDC_CLK_NS - 1) / `DDC_CLK_NS)
`define DDC_RESYNC_CYC ((`DDC_RESYNC_NS + `DDC_CLK_NS - 1) / `DDC_CLK_NS)
`endif

// file: hdl/ddc_pkg.sv
package ddc_pkg;
  typedef enum logic [2:0] {CAL_POD, CAL_HOME, CAL_LONG, CAL_STEP, CAL_HV, CAL_IDLE} ddc_cal_e;
  typedef enum logic [1:0] {ARM_NONE, ARM_HOME, ARM_SEEK, ARM_STEP2} ddc_arm_e;
  typedef enum logic [1:0] {PC_ON, PC_EARLY, PC_LATE} ddc_pc_e;
  typedef struct packed {
    logic [2:0] tag;
    logic [7:0] bus;
    logic sample;
    logic degate;
    logic err_reset;
    logic wr;
    logic rd;
    logic fast_sync;
    logic wr_data;
  } ddc_host_s;
  typedef struct packed {
    logic power_good;
    logic arrived;
    logic vel_over;
    logic read_peak;
    logic servo_inhibit;
    logic unsafe;
    logic not_ready;
    logic brake;
    logic track_unavail;
  } ddc_drive_s;
endpackage : ddc_pkg

// file: hdl/ddc_drive.sv
`timescale 1ns/1ns
`include "ddc_cfg.svh"

module ddc_fifo #(
  parameter int W = 1,
  parameter int D = `DDC_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign in_ready_o = cnt_r != (AW+1)'(D);
  assign out_valid_o = cnt_r != '0;
  assign out_data_o = mem[rp_r];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_comb begin
    wp_nxt = push ? ((wp_r == AW'(D - 1)) ? '0 : wp_r + 1'h1) : wp_r;
    rp_nxt = pop ? ((rp_r == AW'(D - 1)) ? '0 : rp_r + 1'h1) : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wp_r] <= in_data_i;
    end
  end
endmodule : ddc_fifo

// How it works
// - calibration homes with head 1, then seeks track 128 checking velocity
// - gain counter climbs while velocity exceeds profile, stopping at full
// - two-track steps from preset 7, decrement while step under 1.9 ms
// - handover velocity is recalibrated after every calibrate
// - arrival drops seek busy; after settling, seek complete raises interrupt outside calibration
// - tag 001 loads head bits 5..1, decoded to module select and pair
// - write on an invalid head flags command error
// - serial write data enters four-bit shift register on write clock ticks
// - shift bit 3 is current, bit 4 previous, bits 1-2 lookahead
// - bits 4, 3 and 2 choose early, on-time or late write timing
// - selected head reads whenever not writing
// - servo inhibit halts read oscillator
// - fast resync stops oscillator, restarts it on next data peak
// - unsafe condition during write inhibits writing at once
// - tags 100-111 load one of four sense bytes into bus register
// - bus is driven only while degate and power-on hold are off
// - interrupts on completions and on error conditions
// - power good starts 17 s hold, then calibrate and interrupt
// - tag 010 loads bus bits 7..0 as desired track low byte
// - error reset clears unsafe, command error and pending interrupt
// - read and write together raise command error interrupt
module ddc_drive #(
  parameter int POD_CYC = `DDC_POD_CYC,
  parameter int STEP_CYC = `DDC_STEP_CYC,
  parameter int SETTLE_CYC = `DDC_SETTLE_CYC,
  parameter int RESYNC_CYC = `DDC_RESYNC_CYC,
  parameter int GAIN_W = `DDC_GAIN_W,
  parameter int WR_HALF = `DDC_WR_HALF,
  parameter int FIFO_DEPTH = `DDC_FIFO_DEPTH
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // adapter and drive pins
  input wire ddc_pkg::ddc_host_s host_i,
  input wire ddc_pkg::ddc_drive_s drive_i,
  // control bus return
  output logic [7:0] ctl_bus_o,
  output logic ctl_bus_oe_o,
  output logic intr_o,
  // access mechanism
  output ddc_pkg::ddc_arm_e arm_cmd_o,
  output logic [8:0] target_o,
  output logic seek_busy_o,
  output logic seek_complete_o,
  output logic [GAIN_W-1:0] gain_o,
  output logic [2:0] slow_o,
  output logic hv_cal_o,
  // heads and data
  output logic [4:0] module_sel_o,
  output logic [1:0] head_pair_o,
  output logic write_gate_o,
  output logic read_gate_o,
  output logic wr_clk_o,
  output logic wr_ready_o,
  output logic wr_bit_o,
  output ddc_pkg::ddc_pc_e precomp_o,
  output logic osc_run_o,
  output logic osc_restart_o
);
  ddc_pkg::ddc_host_s h1_r, hs_r;
  ddc_pkg::ddc_drive_s d1_r, ds_r;
  logic [4:0] ev_d_r;
  ddc_pkg::ddc_cal_e cal_r, cal_nxt;
  ddc_pkg::ddc_arm_e arm_r, arm_nxt;
  logic [31:0] tmr_r, tmr_nxt, settle_r, settle_nxt, rs_r, rs_nxt;
  logic [GAIN_W-1:0] gain_r, gain_nxt;
  logic [2:0] slow_r, slow_nxt;
  logic [8:0] target_r, target_nxt, desired_r, desired_nxt;
  logic [4:0] head_r, head_nxt, modsel_r, modsel_nxt;
  logic [7:0] bus_r, bus_nxt;
  logic busy_r, busy_nxt, cmp_r, cmp_nxt, hv_r, hv_nxt, home_r, home_nxt;
  logic err_r, err_nxt, unsafe_r, unsafe_nxt, intr_r, intr_nxt, oe_r, oe_nxt;
  logic wg_r, wg_nxt, rg_r, rg_nxt, run_r, run_nxt, rst_r, rst_nxt, wait_r, wait_nxt;
  logic [31:0] div_r, div_nxt;
  logic wclk_r, wclk_nxt, wrdy_r, wrdy_nxt, wbit_r, wbit_nxt;
  logic [3:0] sr_r, sr_nxt;
  ddc_pkg::ddc_pc_e pc_r, pc_nxt;
  logic samp_p, sense0_p, fifo_in_v, fifo_in_r, fifo_out_v, fifo_out_r, fifo_bit, tick;

  function automatic logic head_ok(input logic [4:0] h);
    return h[4:2] < `DDC_MODULES;
  endfunction : head_ok

  function automatic logic [4:0] mod_dec(input logic [4:0] h);
    return head_ok(h) ? 5'(5'h01 << h[4:2]) : 5'h00;
  endfunction : mod_dec

  // pattern {bit4 prev, bit3 current, bit2, bit1}: shift a one away from its neighbour one
  function automatic ddc_pkg::ddc_pc_e pc_dec(input logic [3:0] s);
    if (!s[2] || (s[3] == s[1])) return ddc_pkg::PC_ON;
    return s[3] ? ddc_pkg::PC_LATE : ddc_pkg::PC_EARLY;
  endfunction : pc_dec

  // two-flop input synchronisers
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      h1_r <= '0;
      hs_r <= '0;
      d1_r <= '0;
      ds_r <= '0;
      ev_d_r <= '0;
    end else begin
      h1_r <= host_i;
      hs_r <= h1_r;
      d1_r <= drive_i;
      ds_r <= d1_r;
      ev_d_r <= {hs_r.sample, hs_r.fast_sync, ds_r.not_ready, ds_r.brake, ds_r.track_unavail};
    end
  end

  assign samp_p = hs_r.sample & ~ev_d_r[4];
  assign sense0_p = samp_p & (hs_r.tag == `DDC_TAG_SENSE0);

  always_comb begin
    logic start, done_ev, set_ev;
    ddc_pkg::ddc_arm_e cmd;
    logic [8:0] tgt;
    start = 1'h0;
    done_ev = 1'h0;
    set_ev = 1'h0;
    cmd = ddc_pkg::ARM_NONE;
    tgt = target_r;
    cal_nxt = cal_r;
    tmr_nxt = tmr_r;
    gain_nxt = gain_r;
    slow_nxt = slow_r;
    home_nxt = home_r;
    arm_nxt = ddc_pkg::ARM_NONE;
    hv_nxt = 1'h0;
    target_nxt = target_r;
    busy_nxt = busy_r;
    cmp_nxt = cmp_r;
    settle_nxt = settle_r;
    desired_nxt = desired_r;
    head_nxt = head_r;
    bus_nxt = bus_r;
    err_nxt = err_r;
    unsafe_nxt = unsafe_r;
    intr_nxt = intr_r;
    rs_nxt = rs_r;
    wait_nxt = wait_r;
    rst_nxt = 1'h0;
    if (busy_r && ds_r.arrived) begin
      busy_nxt = 1'h0;
      settle_nxt = 32'(SETTLE_CYC);
    end else if (settle_r != 32'h0) begin
      settle_nxt = settle_r - 32'h1;
      if (settle_r == 32'h1) begin
        cmp_nxt = 1'h1;
        done_ev = 1'h1;
      end
    end
    case (cal_r)
      ddc_pkg::CAL_POD: begin
        if (!ds_r.power_good) begin
          tmr_nxt = 32'h0;
        end else if (tmr_r >= 32'(POD_CYC - 1)) begin
          tmr_nxt = 32'h0;
          cal_nxt = ddc_pkg::CAL_HOME;
          start = 1'h1;
          cmd = ddc_pkg::ARM_HOME;
          head_nxt = 5'h01;
        end else begin
          tmr_nxt = tmr_r + 32'h1;
        end
      end
      ddc_pkg::CAL_HOME: begin
        if (done_ev) begin
          cal_nxt = ddc_pkg::CAL_LONG;
          start = 1'h1;
          cmd = ddc_pkg::ARM_SEEK;
          tgt = `DDC_CAL_TRACK;
          gain_nxt = '0;
        end
      end
      ddc_pkg::CAL_LONG: begin
        if (ds_r.vel_over && gain_r != '1) begin
          gain_nxt = gain_r + 1'h1;
        end
        if (done_ev) begin
          cal_nxt = ddc_pkg::CAL_STEP;
          slow_nxt = `DDC_SLOW_PRESET;
          tmr_nxt = 32'h0;
          start = 1'h1;
          cmd = ddc_pkg::ARM_STEP2;
        end
      end
      ddc_pkg::CAL_STEP: begin
        tmr_nxt = (tmr_r == '1) ? tmr_r : tmr_r + 32'h1;
        if (done_ev) begin
          if (tmr_r < 32'(STEP_CYC) && slow_r != 3'h0) begin
            slow_nxt = slow_r - 3'h1;
            tmr_nxt = 32'h0;
            start = 1'h1;
            cmd = ddc_pkg::ARM_STEP2;
          end else begin
            cal_nxt = ddc_pkg::CAL_HV;
            hv_nxt = 1'h1;
          end
        end
      end
      ddc_pkg::CAL_HV: begin
        cal_nxt = ddc_pkg::CAL_IDLE;
        home_nxt = 1'h1;
        set_ev = 1'h1;
      end
      ddc_pkg::CAL_IDLE: begin
        set_ev = done_ev;
        if (samp_p && hs_r.tag == `DDC_TAG_TRACK && !ds_r.track_unavail) begin
          start = 1'h1;
          cmd = ddc_pkg::ARM_SEEK;
          tgt = {desired_r[8], hs_r.bus};
        end
      end
      default: cal_nxt = ddc_pkg::CAL_POD;
    endcase
    if (!ds_r.power_good) begin
      cal_nxt = ddc_pkg::CAL_POD;
      home_nxt = 1'h0;
    end
    if (start) begin
      busy_nxt = 1'h1;
      cmp_nxt = 1'h0;
      settle_nxt = 32'h0;
      arm_nxt = cmd;
      target_nxt = tgt;
    end
    if (samp_p && hs_r.tag == `DDC_TAG_HEAD) begin
      head_nxt = hs_r.bus[5:1];
      desired_nxt[8] = hs_r.bus[7];
      set_ev = 1'h1;
    end
    if (samp_p && hs_r.tag == `DDC_TAG_TRACK) begin
      desired_nxt[7:0] = hs_r.bus;
    end
    if (samp_p && hs_r.tag[2]) begin
      case (hs_r.tag[1:0])
        2'h0: bus_nxt = {intr_r, ds_r.not_ready, unsafe_r, err_r, ds_r.track_unavail, ds_r.brake, cmp_r, home_r};
        2'h1: bus_nxt = desired_r[7:0];
        2'h2: bus_nxt = {slow_r, gain_r[4:0]};
        2'h3: bus_nxt = {busy_r, wrdy_r, head_ok(head_r), head_r};
        default: bus_nxt = 8'h00;
      endcase
    end
    if (hs_r.err_reset) begin
      unsafe_nxt = 1'h0;
      err_nxt = 1'h0;
    end
    if (hs_r.err_reset || sense0_p) begin
      intr_nxt = 1'h0;
    end
    if (hs_r.wr && (hs_r.rd || !head_ok(head_r))) begin
      err_nxt = 1'h1;
      set_ev = set_ev | ~err_r;
    end
    if (hs_r.wr && ds_r.unsafe) begin
      unsafe_nxt = 1'h1;
      set_ev = set_ev | ~unsafe_r;
    end
    if (|({ds_r.not_ready, ds_r.brake, ds_r.track_unavail} & ~ev_d_r[2:0])) begin
      set_ev = 1'h1;
    end
    if (set_ev) begin
      intr_nxt = 1'h1;
    end
    if (hs_r.fast_sync && !ev_d_r[3]) begin
      rs_nxt = 32'(RESYNC_CYC);
      wait_nxt = 1'h0;
    end else if (rs_r != 32'h0) begin
      rs_nxt = rs_r - 32'h1;
      wait_nxt = rs_r == 32'h1;
    end else if (wait_r && ds_r.read_peak) begin
      wait_nxt = 1'h0;
      rst_nxt = 1'h1;
    end
    modsel_nxt = mod_dec(head_nxt);
    oe_nxt = hs_r.sample && hs_r.tag[2] && !hs_r.degate && cal_r != ddc_pkg::CAL_POD;
    wg_nxt = hs_r.wr && !hs_r.rd && head_ok(head_r) && !unsafe_nxt && !err_nxt;
    rg_nxt = head_ok(head_r) && !hs_r.wr;
    run_nxt = !ds_r.servo_inhibit && rs_nxt == 32'h0 && !wait_nxt;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      cal_r <= ddc_pkg::CAL_POD;
      arm_r <= ddc_pkg::ARM_NONE;
      {tmr_r, settle_r, rs_r} <= '0;
      {gain_r, slow_r, target_r, desired_r, head_r, modsel_r, bus_r} <= '0;
      {busy_r, cmp_r, hv_r, home_r, err_r, unsafe_r, intr_r, oe_r} <= '0;
      {wg_r, rg_r, run_r, rst_r, wait_r} <= '0;
    end else begin
      cal_r <= cal_nxt;
      arm_r <= arm_nxt;
      {tmr_r, settle_r, rs_r} <= {tmr_nxt, settle_nxt, rs_nxt};
      {gain_r, slow_r, target_r, desired_r} <= {gain_nxt, slow_nxt, target_nxt, desired_nxt};
      {head_r, modsel_r, bus_r} <= {head_nxt, modsel_nxt, bus_nxt};
      {busy_r, cmp_r, hv_r, home_r, err_r, unsafe_r, intr_r, oe_r} <=
        {busy_nxt, cmp_nxt, hv_nxt, home_nxt, err_nxt, unsafe_nxt, intr_nxt, oe_nxt};
      {wg_r, rg_r, run_r, rst_r, wait_r} <= {wg_nxt, rg_nxt, run_nxt, rst_nxt, wait_nxt};
    end
  end

  // write path: bits sampled on rising write clock, shifted out on falling
  assign tick = div_r == 32'(WR_HALF - 1);
  assign fifo_in_v = tick & ~wclk_r & hs_r.wr;
  assign fifo_out_r = tick & wclk_r & wg_r;

  ddc_fifo #(.W(1), .D(FIFO_DEPTH)) u_fifo (
    .clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .in_valid_i(fifo_in_v),
    .in_ready_o(fifo_in_r),
    .in_data_i(hs_r.wr_data),
    .out_valid_o(fifo_out_v),
    .out_ready_i(fifo_out_r),
    .out_data_o(fifo_bit)
  );

  always_comb begin
    div_nxt = tick ? 32'h0 : div_r + 32'h1;
    wclk_nxt = tick ? ~wclk_r : wclk_r;
    wrdy_nxt = fifo_in_r;
    sr_nxt = (fifo_out_r && fifo_out_v) ? {sr_r[2:0], fifo_bit} : sr_r;
    wbit_nxt = sr_nxt[2];
    pc_nxt = pc_dec({sr_nxt[3], sr_nxt[2], sr_nxt[1], sr_nxt[0]});
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      {div_r, wclk_r, wrdy_r, sr_r, wbit_r} <= '0;
      pc_r <= ddc_pkg::PC_ON;
    end else begin
      {div_r, wclk_r, wrdy_r, sr_r, wbit_r} <= {div_nxt, wclk_nxt, wrdy_nxt, sr_nxt, wbit_nxt};
      pc_r <= pc_nxt;
    end
  end

  assign {ctl_bus_o, ctl_bus_oe_o, intr_o, arm_cmd_o, target_o} = {bus_r, oe_r, intr_r, arm_r, target_r};
  assign {seek_busy_o, seek_complete_o, gain_o, slow_o, hv_cal_o} = {busy_r, cmp_r, gain_r, slow_r, hv_r};
  assign {module_sel_o, head_pair_o, write_gate_o, read_gate_o} = {modsel_r, head_r[1:0], wg_r, rg_r};
  assign {wr_clk_o, wr_ready_o, wr_bit_o, precomp_o, osc_run_o, osc_restart_o} =
    {wclk_r, wrdy_r, wbit_r, pc_r, run_r, rst_r};

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence arrive_s;
    seek_busy_o ##1 !seek_busy_o;
  endsequence
  sequence settled_s;
    !seek_complete_o [*3];
  endsequence

  gain_climb_a: assert property ((cal_r == ddc_pkg::CAL_LONG && ds_r.vel_over && gain_r != '1)
    |=> gain_o == $past(gain_o) + 1'h1) else $error("gain did not climb");
  slow_preset_a: assert property ((cal_r == ddc_pkg::CAL_LONG && cal_nxt == ddc_pkg::CAL_STEP)
    |=> slow_o == 3'h7 && arm_cmd_o == ddc_pkg::ARM_STEP2) else $error("step preset wrong");
  hv_after_cal_a: assert property ($rose(home_r) |-> $past(hv_cal_o)) else $error("no handover pulse");
  settle_wait_a: assert property (arrive_s |-> settled_s) else $error("complete before settle");
  head_load_a: assert property ((samp_p && hs_r.tag == `DDC_TAG_HEAD)
    |=> head_pair_o == $past(hs_r.bus[2:1]) && module_sel_o == mod_dec($past(hs_r.bus[5:1])))
    else $error("head select wrong");
  bad_cmd_a: assert property ((hs_r.wr && (hs_r.rd || !head_ok(head_r)))
    |=> err_r && !write_gate_o && (intr_o || $past(err_r))) else $error("bad command not flagged");
  unsafe_block_a: assert property (unsafe_r |-> !write_gate_o) else $error("write while unsafe");
  bus_gate_a: assert property ((hs_r.degate || cal_r == ddc_pkg::CAL_POD) |=> !ctl_bus_oe_o)
    else $error("bus driven while gated");
  intr_hold_a: assert property ((intr_o && !hs_r.err_reset && !sense0_p) |=> intr_o)
    else $error("interrupt dropped early");
  osc_stop_a: assert property (ds_r.servo_inhibit |=> !osc_run_o) else $error("oscillator ran in servo area");
  read_sel_a: assert property ((head_ok(head_r) && !hs_r.wr) |=> read_gate_o) else $error("head not reading");
endmodule : ddc_drive

// file: tb/ddc_mech.sv
`timescale 1ns/1ns
module ddc_mech #(
  parameter int SEEK_CYC = 40,
  parameter int MOVE_CYC = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // arm command from the drive logic
  input wire ddc_pkg::ddc_arm_e arm_cmd_i,
  // arm sensors
  output logic arrived_o,
  output logic vel_over_o
);
  int cnt;
  logic seek_r;
  // on-target shows for 4 cycles at the end of each move, longer than the input sync
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      cnt <= 0;
      seek_r <= 1'b0;
    end else if (arm_cmd_i != ddc_pkg::ARM_NONE) begin
      seek_r <= (arm_cmd_i == ddc_pkg::ARM_SEEK);
      cnt <= ((arm_cmd_i == ddc_pkg::ARM_SEEK) ? SEEK_CYC : MOVE_CYC) + 4;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  assign arrived_o = (cnt >= 1) && (cnt <= 4);
  // a long seek always outruns the profile, so the gain counter must saturate
  assign vel_over_o = seek_r && (cnt > 4);
endmodule : ddc_mech

// file: tb/tb.sv
`timescale 1ns/1ns
module tb;
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  ddc_pkg::ddc_host_s h;
  ddc_pkg::ddc_drive_s d;
  ddc_pkg::ddc_drive_s drv;
  logic m_arr, m_vel;
  logic [7:0] ctl_bus_o;
  logic ctl_bus_oe_o, intr_o, seek_busy_o, seek_complete_o, hv_cal_o;
  ddc_pkg::ddc_arm_e arm_cmd_o;
  logic [8:0] target_o;
  logic [4:0] gain_o;
  logic [2:0] slow_o;
  logic [4:0] module_sel_o;
  logic [1:0] head_pair_o;
  logic write_gate_o, read_gate_o, wr_clk_o, wr_ready_o, wr_bit_o, osc_run_o, osc_restart_o;
  ddc_pkg::ddc_pc_e precomp_o;
  int err_count = 0;
  int comparisons = 0;
  ddc_pkg::ddc_arm_e arms[$];
  logic [8:0] tgts[$];
  logic hv_seen = 1'b0;
  logic [7:0] b;
  logic oe;

  always #50 ref_clk_i = ~ref_clk_i;
  always_comb begin
    drv = d;
    drv.arrived = m_arr;
    drv.vel_over = m_vel;
  end

  ddc_drive #(.POD_CYC(20), .STEP_CYC(30), .SETTLE_CYC(4)) ddc_drive_inst (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .host_i(h), .drive_i(drv),
    .ctl_bus_o(ctl_bus_o), .ctl_bus_oe_o(ctl_bus_oe_o), .intr_o(intr_o),
    .arm_cmd_o(arm_cmd_o), .target_o(target_o), .seek_busy_o(seek_busy_o),
    .seek_complete_o(seek_complete_o), .gain_o(gain_o), .slow_o(slow_o), .hv_cal_o(hv_cal_o),
    .module_sel_o(module_sel_o), .head_pair_o(head_pair_o), .write_gate_o(write_gate_o),
    .read_gate_o(read_gate_o), .wr_clk_o(wr_clk_o), .wr_ready_o(wr_ready_o), .wr_bit_o(wr_bit_o),
    .precomp_o(precomp_o), .osc_run_o(osc_run_o), .osc_restart_o(osc_restart_o));

  ddc_mech ddc_mech_inst (.clk_i(ref_clk_i), .resetn_i(resetn_i), .arm_cmd_i(arm_cmd_o),
    .arrived_o(m_arr), .vel_over_o(m_vel));

  always @(posedge ref_clk_i) begin
    if (arm_cmd_o != ddc_pkg::ARM_NONE) begin
      arms.push_back(arm_cmd_o);
      tgts.push_back(target_o);
    end
    if (hv_cal_o === 1'b1) hv_seen = 1'b1;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask : cyc

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // one control-sample cycle; fields settle 3 cycles before and after the strobe
  task automatic xfer(input logic [2:0] t, input logic [7:0] v);
    h.tag = t;
    h.bus = v;
    cyc(3);
    h.sample = 1'b1;
    cyc(5);
    b = ctl_bus_o;
    oe = ctl_bus_oe_o;
    h.sample = 1'b0;
    cyc(3);
  endtask : xfer

  task automatic erst();
    h.err_reset = 1'b1;
    cyc(4);
    h.err_reset = 1'b0;
    cyc(3);
  endtask : erst

  task automatic t_cal();
    int n;
    xfer(3'h4, 8'h00);
    chk(oe, 1'b0);
    for (n = 0; n < 3000 && intr_o !== 1'b1; n++) cyc(1);
    chk(n >= 20, 1'b1);
    chk(arms.size(), 10);
    chk(arms[0], ddc_pkg::ARM_HOME);
    chk({arms[1], tgts[1]}, {ddc_pkg::ARM_SEEK, 9'h080});
    chk(arms[9], ddc_pkg::ARM_STEP2);
    chk({module_sel_o, head_pair_o}, {5'h01, 2'h1});
    chk(hv_seen, 1'b1);
    chk({slow_o, gain_o}, {3'h0, 5'h1F});
    xfer(3'h6, 8'h00);
    chk(b, {3'h0, 5'h1F});
    xfer(3'h4, 8'h00);
    chk(b & 8'h7F, 8'h03);
    chk(intr_o, 1'b0);
  endtask : t_cal

  task automatic t_seek();
    int n;
    xfer(3'h1, 8'h00);
    chk(intr_o, 1'b1);
    xfer(3'h2, 8'h5A);
    chk({arms[$], tgts[$]}, {ddc_pkg::ARM_SEEK, 9'h05A});
    chk(seek_busy_o, 1'b1);
    xfer(3'h4, 8'h00);
    for (n = 0; n < 200 && seek_busy_o !== 1'b0; n++) cyc(1);
    chk(intr_o, 1'b0);
    for (n = 0; n < 50 && seek_complete_o !== 1'b1; n++) cyc(1);
    chk(n, 4);
    chk(intr_o, 1'b1);
    cyc(1);
    chk(intr_o, 1'b1);
    h.degate = 1'b1;
    xfer(3'h5, 8'h00);
    chk(oe, 1'b0);
    h.degate = 1'b0;
    xfer(3'h5, 8'h00);
    chk({oe, b}, {1'b1, 8'h5A});
    chk(intr_o, 1'b1);
    xfer(3'h4, 8'h00);
    chk(intr_o, 1'b0);
    xfer(3'h7, 8'h00);
    chk(b, 8'h60);
  endtask : t_seek

  task automatic t_err();
    int k;
    k = arms.size();
    d.track_unavail = 1'b1;
    d.not_ready = 1'b1;
    cyc(4);
    chk(intr_o, 1'b1);
    xfer(3'h2, 8'h33);
    chk(arms.size(), k);
    xfer(3'h4, 8'h00);
    chk(b & 8'h48, 8'h48);
    chk(intr_o, 1'b0);
    xfer(3'h5, 8'h00);
    chk(b, 8'h33);
    d.track_unavail = 1'b0;
    d.not_ready = 1'b0;
    cyc(3);
  endtask : t_err

  task automatic t_sync();
    logic rs;
    h.fast_sync = 1'b1;
    cyc(4);
    h.fast_sync = 1'b0;
    chk(osc_run_o, 1'b0);
    cyc(10);
    chk(osc_run_o, 1'b0);
    d.read_peak = 1'b1;
    rs = 1'b0;
    repeat (6) begin
      cyc(1);
      if (osc_restart_o === 1'b1) rs = 1'b1;
    end
    d.read_peak = 1'b0;
    chk({rs, osc_run_o}, 2'h3);
    d.servo_inhibit = 1'b1;
    cyc(4);
    chk(osc_run_o, 1'b0);
    d.servo_inhibit = 1'b0;
    cyc(4);
    chk(osc_run_o, 1'b1);
  endtask : t_sync

  task automatic t_write();
    logic e, l, rg;
    logic [1:0] wb;
    int nr;
    e = 1'b0;
    wb = 2'h0;
    nr = 0;
    l = 1'b0;
    rg = 1'b0;
    xfer(3'h1, 8'h0A);
    erst();
    h.wr = 1'b1;
    cyc(3);
    // four zero bits then four one bits, one bit per write clock period
    for (int i = 0; i < 240; i++) begin
      h.wr_data = i[4];
      cyc(1);
      if (precomp_o === ddc_pkg::PC_EARLY) e = 1'b1;
      if (precomp_o === ddc_pkg::PC_LATE) l = 1'b1;
      if (read_gate_o !== 1'b0) rg = 1'b1;
      if (wr_clk_o === 1'b1) nr++;
      wb[wr_bit_o === 1'b1] = 1'b1;
    end
    chk(write_gate_o, 1'b1);
    chk(nr, 120);
    chk(wb, 2'h3);
    chk({e, l}, 2'h3);
    chk(rg, 1'b0);
    d.unsafe = 1'b1;
    cyc(6);
    chk({write_gate_o, intr_o}, 2'h1);
    xfer(3'h4, 8'h00);
    chk(b[5], 1'b1);
    d.unsafe = 0;
    h.wr = 1'b0;
    erst();
    chk(read_gate_o, 1'b1);
  endtask : t_write

  task automatic t_head();
    int hs[6] = '{0, 7, 18, 19, 20, 31};
    int m;
    foreach (hs[i]) begin
      m = hs[i] >> 2;
      xfer(3'h1, {2'h0, hs[i][4:0], 1'b0});
      chk(module_sel_o, (m < 5) ? (5'h01 << m) : 5'h00);
      chk(head_pair_o, hs[i][1:0]);
    end
    h.wr = 1'b1;
    cyc(60);
    chk(write_gate_o, 1'b0);
    chk(wr_ready_o, 1'b0);
    xfer(3'h4, 8'h00);
    chk(b[4], 1'b1);
    h.wr = 1'b0;
    erst();
    chk(intr_o, 1'b0);
    xfer(3'h4, 8'h00);
    chk(b[5:4], 2'h0);
    xfer(3'h1, 8'h0A);
    erst();
    h.wr = 1'b1;
    h.rd = 1'b1;
    cyc(6);
    chk({intr_o, write_gate_o}, 2'h2);
    h.wr = 1'b0;
    h.rd = 1'b0;
    erst();
  endtask : t_head

  task automatic test_done();
    if (err_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  initial begin
    #2000000;
    err_count++;
    test_done();
  end

  initial begin
    h = '0;
    d = '0;
    d.power_good = 1'b1;
    repeat (3) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    resetn_i = 1'b1;
    t_cal();
    t_seek();
    t_err();
    t_sync();
    t_write();
    t_head();
    test_done();
  end
endmodule : tb
